// *** design/ivd_top.sv ***
/*
  Interrupt vector dispatch: table base, level registers, compat swap and vector lookup
  behind an AXI4-Lite slave.
  Assumes the core issues lookups synchronously on i_core_clk and the boot sequencer
  pulses i_boot_done for one cycle when the boot program ends.
*/
`timescale 1ns/1ps
module ivd_top
  import ivd_pkg::*;
(
  input  wire logic                i_core_clk,
  input  wire logic                i_resetn,
  input  wire logic [IVD_AW-1:0]   i_s_axi_awaddr,
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  output logic [1:0]               o_s_axi_bresp,
  output logic                     o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  input  wire logic [IVD_AW-1:0]   i_s_axi_araddr,
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  output logic [31:0]              o_s_axi_rdata,
  output logic [1:0]               o_s_axi_rresp,
  output logic                     o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready,
  input  wire logic                i_boot_done,
  input  wire logic                i_vec_req,
  input  wire logic [7:0]          i_vec_num,
  input  wire logic                i_vec_dma,
  output logic                     o_vec_valid,
  output logic [31:0]              o_vec_addr,
  output logic [7:0]               o_vec_level,
  output logic                     o_vec_level_ok,
  output logic                     o_vec_trap,
  output logic                     o_vec_secure,
  output logic                     o_dma_ok,
  output logic [6:0]               o_dma_rn,
  output logic                     o_dma_rn2_ok,
  output logic [6:0]               o_dma_rn2,
  output logic                     o_dma_stop,
  output logic                     o_dma_trig
);

  typedef struct packed {
    logic                    aw_pend;
    logic [13:0]             aw_idx;
    logic                    w_pend;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [31:0]             vbase;
    logic [7:0]              compat;
    logic [IVD_NLVL-1:0][7:0] lvl;
    logic                    v_valid;
    logic [31:0]             v_addr;
    logic [7:0]              v_level;
    logic                    v_level_ok;
    logic                    v_trap;
    logic                    v_secure;
    logic                    d_ok;
    logic [6:0]              d_rn;
    logic                    d_rn2_ok;
    logic [6:0]              d_rn2;
    logic                    d_stop;
    logic                    d_trig;
  } ivd_state_t;

  localparam ivd_state_t IVD_STATE_RESET = '{
    aw_pend:  1'b0, aw_idx: 14'h0000, w_pend: 1'b0, w_data: 32'h00000000, w_strb: 4'h0,
    bvalid:   1'b0, bresp: IVD_RESP_OKAY, rvalid: 1'b0, rdata: 32'h00000000,
    rresp:    IVD_RESP_OKAY, vbase: IVD_BASE_RESET, compat: IVD_COMPAT_RST,
    lvl:      {IVD_NLVL{IVD_LVL_RESET}}, v_valid: 1'b0, v_addr: 32'h00000000,
    v_level:  8'h00, v_level_ok: 1'b0, v_trap: 1'b0, v_secure: 1'b0, d_ok: 1'b0,
    d_rn:     7'h00, d_rn2_ok: 1'b0, d_rn2: 7'h00, d_stop: 1'b0, d_trig: 1'b0};

  ivd_state_t s_q;
  ivd_state_t s_d;

  logic [31:0] calc_addr;
  logic        calc_trap;
  logic        calc_secure;
  logic        calc_dma_ok;
  logic [6:0]  calc_dma_rn;
  logic        calc_dma_rn2_ok;
  logic [6:0]  calc_dma_rn2;
  logic        calc_dma_stop;

  ivd_vec_calc u_calc (
    .i_base       (s_q.vbase),
    .i_num        (i_vec_num),
    .o_addr       (calc_addr),
    .o_trap       (calc_trap),
    .o_secure     (calc_secure),
    .o_dma_ok     (calc_dma_ok),
    .o_dma_rn     (calc_dma_rn),
    .o_dma_rn2_ok (calc_dma_rn2_ok),
    .o_dma_rn2    (calc_dma_rn2),
    .o_dma_stop   (calc_dma_stop)
  );

  // Accept AW or W only while its holding slot is empty and no write response waits; AR only while no read response waits
  assign o_s_axi_awready = !s_q.aw_pend && !s_q.bvalid;
  assign o_s_axi_wready  = !s_q.w_pend && !s_q.bvalid;
  assign o_s_axi_arready = !s_q.rvalid;

  always_comb begin
    logic        aw_now;
    logic [13:0] aw_idx;
    logic        w_now;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        hit;
    logic [13:0] ar_idx;
    logic [31:0] rd;
    logic        rd_hit;
    logic [7:0]  lvl_num;
    logic [7:0]  want;
    logic        lvl_found;
    logic [7:0]  lvl_val;

    s_d = s_q;
    aw_now = s_q.aw_pend;
    aw_idx = s_q.aw_idx;
    w_now = s_q.w_pend;
    wdata = s_q.w_data;
    wstrb = s_q.w_strb;
    hit = 1'b0;
    ar_idx = i_s_axi_araddr[IVD_AW-1:2];
    rd = 32'h00000000;
    rd_hit = 1'b0;
    lvl_num = 8'h00;
    want = 8'h00;
    lvl_found = 1'b0;
    lvl_val = 8'h00;

    if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_now = 1'b1;
      aw_idx = i_s_axi_awaddr[IVD_AW-1:2];
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_now = 1'b1;
      wdata = i_s_axi_wdata;
      wstrb = i_s_axi_wstrb;
    end
    s_d.aw_pend = aw_now;
    s_d.aw_idx = aw_idx;
    s_d.w_pend = w_now;
    s_d.w_data = wdata;
    s_d.w_strb = wstrb;

    if (s_q.bvalid && i_s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Write commits once address and data are both held
    if (aw_now && w_now) begin
      s_d.aw_pend = 1'b0;
      s_d.w_pend = 1'b0;
      s_d.bvalid = 1'b1;
      if (aw_idx == IVD_IDX_BASE) begin
        hit = 1'b1;
        for (int b = 0; b < 4; b++) begin
          if (wstrb[b]) begin
            s_d.vbase[b*8 +: 8] = wdata[b*8 +: 8];
          end
        end
      end
      if (aw_idx == IVD_IDX_COMPAT) begin
        hit = 1'b1;
        if (wstrb[0]) begin
          s_d.compat = wdata[7:0];
        end
      end
      if (aw_idx == IVD_IDX_LASTVEC) begin
        hit = 1'b1;
      end
      for (int i = 0; i < IVD_NLVL; i++) begin
        if (aw_idx == IVD_LVL_IDX[i]) begin
          hit = 1'b1;
          if (wstrb[0]) begin
            s_d.lvl[i] = wdata[7:0];
          end
        end
      end
      s_d.bresp = hit ? IVD_RESP_OKAY : IVD_RESP_SLVERR;
    end

    // Boot end outranks a software write to the base in the same cycle
    if (i_boot_done) begin
      s_d.vbase = IVD_BASE_RESET;
    end

    if (s_q.rvalid && i_s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      if (ar_idx == IVD_IDX_BASE) begin
        rd_hit = 1'b1;
        rd = s_q.vbase;
      end
      if (ar_idx == IVD_IDX_COMPAT) begin
        rd_hit = 1'b1;
        rd = {24'h000000, s_q.compat};
      end
      if (ar_idx == IVD_IDX_LASTVEC) begin
        rd_hit = 1'b1;
        rd = s_q.v_addr;
      end
      for (int i = 0; i < IVD_NLVL; i++) begin
        if (ar_idx == IVD_LVL_IDX[i]) begin
          rd_hit = 1'b1;
          rd = {24'h000000, s_q.lvl[i]};
        end
      end
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rd_hit ? IVD_RESP_OKAY : IVD_RESP_SLVERR;
    end

    // Two vector numbers share one level register
    lvl_num = 8'((i_vec_num - IVD_NUM_FIRST) >> 1);
    want = lvl_num;
    if (s_q.compat[IVD_COMPAT_BIT]) begin
      if (lvl_num == IVD_LVL_NUM[IVD_SLOT_23]) begin
        want = IVD_LVL_NUM[IVD_SLOT_47];
      end else if (lvl_num == IVD_LVL_NUM[IVD_SLOT_47]) begin
        want = IVD_LVL_NUM[IVD_SLOT_23];
      end
    end
    if (i_vec_num >= IVD_NUM_FIRST && i_vec_num <= IVD_NUM_LAST) begin
      for (int i = 0; i < IVD_NLVL; i++) begin
        if (want == IVD_LVL_NUM[i]) begin
          lvl_found = 1'b1;
          lvl_val = s_q.lvl[i];
        end
      end
    end

    s_d.v_valid = i_vec_req;
    s_d.d_trig = 1'b0;
    if (i_vec_req) begin
      s_d.v_addr = calc_addr;
      s_d.v_level = lvl_val;
      s_d.v_level_ok = lvl_found;
      s_d.v_trap = calc_trap;
      s_d.v_secure = calc_secure;
      s_d.d_ok = calc_dma_ok;
      s_d.d_rn = calc_dma_rn;
      s_d.d_rn2_ok = calc_dma_rn2_ok;
      s_d.d_rn2 = calc_dma_rn2;
      s_d.d_stop = calc_dma_stop;
      s_d.d_trig = i_vec_dma && calc_dma_ok;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= IVD_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_s_axi_bresp  = s_q.bresp;
  assign o_s_axi_bvalid = s_q.bvalid;
  assign o_s_axi_rdata  = s_q.rdata;
  assign o_s_axi_rresp  = s_q.rresp;
  assign o_s_axi_rvalid = s_q.rvalid;
  assign o_vec_valid    = s_q.v_valid;
  assign o_vec_addr     = s_q.v_addr;
  assign o_vec_level    = s_q.v_level;
  assign o_vec_level_ok = s_q.v_level_ok;
  assign o_vec_trap     = s_q.v_trap;
  assign o_vec_secure   = s_q.v_secure;
  assign o_dma_ok       = s_q.d_ok;
  assign o_dma_rn       = s_q.d_rn;
  assign o_dma_rn2_ok   = s_q.d_rn2_ok;
  assign o_dma_rn2      = s_q.d_rn2;
  assign o_dma_stop     = s_q.d_stop;
  assign o_dma_trig     = s_q.d_trig;

endmodule

// *** design/ivd_pkg.sv ***
/*
  Constants, register map and reset values for the interrupt vector dispatch block.
  Assumes a single core clock domain and an AXI4-Lite register slave with 16 address bits.
*/
package ivd_pkg;

  localparam int          IVD_AW          = 16;
  localparam int          IVD_NLVL        = 12;
  localparam logic [31:0] IVD_BASE_RESET  = 32'h000ffc00;
  localparam logic [7:0]  IVD_LVL_RESET   = 8'h00;
  localparam logic [7:0]  IVD_COMPAT_RST  = 8'h00;
  localparam logic [9:0]  IVD_OFS_TOP     = 10'h3fc;
  localparam logic [7:0]  IVD_TRAP_FIRST  = 8'h91;
  localparam logic [7:0]  IVD_SECURE_NUM  = 8'h90;
  localparam logic [7:0]  IVD_NUM_FIRST   = 8'h10;
  localparam logic [7:0]  IVD_NUM_LAST    = 8'h8f;
  localparam int          IVD_COMPAT_BIT  = 0;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IVD_IDX_COMPAT  = 14'h0c03;
  localparam logic [13:0] IVD_IDX_BASE    = 14'h0500;
  localparam logic [13:0] IVD_IDX_LASTVEC = 14'h0501;

  // Level register slots: level register number and register index
  localparam logic [7:0] IVD_LVL_NUM [IVD_NLVL] = '{
    8'd23, 8'd47, 8'd54, 8'd55, 8'd56, 8'd57, 8'd58, 8'd59, 8'd60, 8'd61, 8'd62, 8'd63};
  localparam logic [13:0] IVD_LVL_IDX [IVD_NLVL] = '{
    14'h0457, 14'h046f, 14'h0476, 14'h0477, 14'h0478, 14'h0479,
    14'h047a, 14'h047b, 14'h047c, 14'h047d, 14'h047e, 14'h047f};
  localparam int IVD_SLOT_23 = 0;
  localparam int IVD_SLOT_47 = 1;

  // DMA resource numbers
  localparam logic [7:0] IVD_NUM_PPG12  = 8'h7c;
  localparam logic [7:0] IVD_NUM_PPG15  = 8'h7f;
  localparam logic [7:0] IVD_NUM_ADC0   = 8'h86;
  localparam logic [6:0] IVD_RES_PPG12  = 7'd108;
  localparam logic [6:0] IVD_RES_ADC0_A = 7'd14;
  localparam logic [6:0] IVD_RES_ADC0_B = 7'd112;

  localparam logic [1:0] IVD_RESP_OKAY   = 2'b00;
  localparam logic [1:0] IVD_RESP_SLVERR = 2'b10;

endpackage

// *** design/ivd_vec_calc.sv ***
/*
  Combinational vector address, trap and DMA attribute lookup for one vector number.
  Assumes the caller registers the results.
*/
`timescale 1ns/1ps
module ivd_vec_calc
  import ivd_pkg::*;
(
  input  wire logic [31:0] i_base,
  input  wire logic [7:0]  i_num,
  output logic      [31:0] o_addr,
  output logic             o_trap,
  output logic             o_secure,
  output logic             o_dma_ok,
  output logic      [6:0]  o_dma_rn,
  output logic             o_dma_rn2_ok,
  output logic      [6:0]  o_dma_rn2,
  output logic             o_dma_stop
);
  logic [9:0] offset;

  always_comb begin
    offset = IVD_OFS_TOP - {i_num, 2'b00};
    o_addr = i_base + {22'h000000, offset};
    o_trap = (i_num >= IVD_TRAP_FIRST);
    o_secure = (i_num == IVD_SECURE_NUM);
    o_dma_ok = 1'b0;
    o_dma_rn = 7'h00;
    o_dma_rn2_ok = 1'b0;
    o_dma_rn2 = 7'h00;
    // No source in this range can request a DMA stop
    o_dma_stop = 1'b0;
    if (i_num >= IVD_NUM_PPG12 && i_num <= IVD_NUM_PPG15) begin
      o_dma_ok = 1'b1;
      o_dma_rn = IVD_RES_PPG12 + 7'(i_num - IVD_NUM_PPG12);
    end else if (i_num == IVD_NUM_ADC0) begin
      o_dma_ok = 1'b1;
      o_dma_rn = IVD_RES_ADC0_A;
      o_dma_rn2_ok = 1'b1;
      o_dma_rn2 = IVD_RES_ADC0_B;
    end
  end
endmodule

// *** dv/ivd_assertions.sv ***
/* Port checker for ivd_top: lookup timing, addresses, trap and DMA attributes.
   Assumes it is bound to ivd_top with one clock and active-low reset. */
`timescale 1ns/1ps
module ivd_assertions (
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_boot_done,
  input wire logic        i_s_axi_awvalid,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_vec_req,
  input wire logic [7:0]  i_vec_num,
  input wire logic        i_vec_dma,
  input wire logic        o_vec_valid,
  input wire logic [31:0] o_vec_addr,
  input wire logic        o_vec_trap,
  input wire logic        o_dma_ok,
  input wire logic [6:0]  o_dma_rn,
  input wire logic        o_dma_stop,
  input wire logic        o_dma_trig
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic clean_q;
  // The base is known only until software may have rewritten it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) clean_q <= 1'h1;
    else if (i_boot_done) clean_q <= 1'h1;
    else if (i_s_axi_awvalid) clean_q <= 1'h0;
  end
  default_base_a: assert property (i_vec_req && clean_q |=>
    o_vec_addr == 32'h000ffffc - 32'({$past(i_vec_num), 2'h0})) else $error("default vector address wrong");
  lookup_valid_a: assert property (i_vec_req |=> o_vec_valid)
    else $error("lookup not answered");
  lookup_quiet_a: assert property (!i_vec_req |=> !o_vec_valid && !o_dma_trig)
    else $error("result without request");
  trap_range_a: assert property (i_vec_req |=> o_vec_trap == ($past(i_vec_num) >= 8'h91))
    else $error("trap flag wrong");
  dma_trig_a: assert property (i_vec_req |=> o_dma_trig ==
    ($past(i_vec_dma) && ($past(i_vec_num) inside {[8'h7c:8'h7f], 8'h86}))) else $error("dma trigger wrong");
  adc_rn_a: assert property (i_vec_req && i_vec_num == 8'h86 |=> o_dma_ok && o_dma_rn == 7'h0e)
    else $error("resource number wrong");
  no_stop_a: assert property (o_vec_valid |-> !o_dma_stop)
    else $error("stop attribute set");
  read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered");
endmodule
bind ivd_top ivd_assertions u_chk (.*);

// *** dv/ivd_core_model.sv ***
/* Core-side model that issues vector lookups when the bench commands them.
   Assumes commands change just after a rising edge of i_clk. */
`timescale 1ns/1ps
module ivd_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_go,
  input  wire logic [7:0] i_num,
  input  wire logic       i_dma,
  output logic            o_req,
  output logic [7:0]      o_num,
  output logic            o_dma
);
  // Idle cycles invert the number so a stale value never passes for a request
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req <= 1'h0;
      o_num <= 8'h0;
      o_dma <= 1'h0;
    end else begin
      o_req <= i_go;
      o_num <= i_go ? i_num : ~o_num;
      o_dma <= i_go & i_dma;
    end
  end
endmodule

// *** dv/tb_interrupt_vector_dispatch.sv ***
/* Bench for ivd_top: AXI4-Lite master, core model and a reference model.
   Assumes the checker binds itself to ivd_top. */
`timescale 1ns/1ps
module tb_interrupt_vector_dispatch;
  logic        i_core_clk = 1'h0, i_resetn = 1'h0, i_boot_done = 1'h0, go = 1'h0, gdma = 1'h0;
  logic [15:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
  logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, o_vec_addr, base, last, seed = 32'h6e5a85af;
  logic [3:0]  i_s_axi_wstrb = 4'hf;
  logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0, i_vec_req, i_vec_dma, o_vec_valid;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic        o_vec_level_ok, o_vec_trap, o_vec_secure, o_dma_ok, o_dma_rn2_ok, o_dma_stop, o_dma_trig;
  logic [7:0]  i_vec_num, o_vec_level, gnum = 8'h0, comp, lvl [64];
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [6:0]  o_dma_rn, o_dma_rn2;
  logic [8:0]  q [$];
  logic [8:0]  hd;
  int          errors = 0, cmp_count = 0, cyc = 0;
  ivd_top dut (.*);
  ivd_core_model core (.i_clk(i_core_clk), .i_resetn(i_resetn), .i_go(go), .i_num(gnum), .i_dma(gdma),
                       .o_req(i_vec_req), .o_num(i_vec_num), .o_dma(i_vec_dma));
  always #5 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int lvn(input logic [15:0] a);
    int n;
    n = (int'(a) - 32'h1100) / 4;
    return (a >= 16'h1100 && a < 16'h1200 && (n == 23 || n == 47 || n >= 54)) ? n : -1;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic mreset();
    base = 32'h000ffc00;
    comp = 8'h0;
    last = '0;
    q.delete();
    foreach (lvl[i]) lvl[i] = 8'h0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (!o_s_axi_bvalid);
    i_s_axi_bready <= 1'h0;
    chk(o_s_axi_bresp, (lvn(a) >= 0 || a inside {16'h1400, 16'h1404, 16'h300c}) ? 2'h0 : 2'h2);
    if (a == 16'h1400) base = d;
    if (a == 16'h300c) comp = d[7:0];
    if (lvn(a) >= 0) lvl[lvn(a)] = d[7:0];
  endtask
  task automatic rdchk(input logic [15:0] a);
    int n;
    n = lvn(a);
    @(posedge i_core_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    do begin
      @(posedge i_core_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'h0;
    chk(o_s_axi_rresp, (n >= 0 || a inside {16'h1400, 16'h1404, 16'h300c}) ? 2'h0 : 2'h2);
    chk(o_s_axi_rdata, n >= 0 ? lvl[n] : a == 16'h1400 ? base : a == 16'h1404 ? last :
        a == 16'h300c ? comp : 32'h0);
  endtask
  task automatic sweep();
    for (int a = 32'h1100; a < 32'h1200; a += 4) rdchk(16'(a));
    rdchk(16'h1400);
    rdchk(16'h1404);
    rdchk(16'h300c);
    rdchk(16'h2000);
  endtask
  task automatic lookups();
    logic [31:0] r;
    for (int n = 0; n < 256; n++) begin
      @(posedge i_core_clk);
      r = rnd();
      go <= 1'h1;
      gnum <= 8'(n);
      gdma <= r[0];
      if (r[1]) begin
        @(posedge i_core_clk);
        go <= 1'h0;
      end
    end
    @(posedge i_core_clk);
    go <= 1'h0;
    repeat (3) @(posedge i_core_clk);
    chk(q.size(), 0);
  endtask
  task automatic check_vec(input logic [7:0] n, input logic d);
    int k;
    logic ok;
    k = (int'(n) - 16) / 2;
    if (comp[0] && k == 23) k = 47;
    else if (comp[0] && k == 47) k = 23;
    ok = n >= 8'h10 && n <= 8'h8f && (k == 23 || k == 47 || k >= 54);
    last = base + 32'h3fc - {n, 2'h0};
    chk(o_vec_addr, last);
    chk(o_vec_level_ok, ok);
    chk(o_vec_level, ok ? lvl[k] : 8'h0);
    chk(o_vec_trap, n >= 8'h91);
    ok = n inside {[8'h7c:8'h7f], 8'h86};
    chk(o_dma_ok, ok);
    chk(o_dma_trig, ok && d);
    if (ok) chk(o_dma_rn, n == 8'h86 ? 32'he : n - 16);
    chk(o_dma_rn2_ok, n == 8'h86);
    if (n == 8'h86) chk(o_dma_rn2, 32'd112);
    chk(o_vec_secure, n == 8'h90);
    chk(o_dma_stop, 1'h0);
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
    if (i_resetn && o_vec_valid) begin
      hd = q.pop_front();
      check_vec(hd[7:0], hd[8]);
    end
    if (i_resetn && i_vec_req) q.push_back({i_vec_dma, i_vec_num});
  end
  initial begin
    mreset();
    repeat (12) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    sweep();
    lookups();
    for (int k = 0; k < 64; k++) wr(16'h1100 + 16'(4 * k), rnd());
    wr(16'h1404, rnd());
    wr(16'h0000, rnd());
    sweep();
    wr(16'h300c, 32'h1);
    lookups();
    wr(16'h1400, rnd());
    lookups();
    @(posedge i_core_clk);
    i_boot_done <= 1'h1;
    @(posedge i_core_clk);
    i_boot_done <= 1'h0;
    base = 32'h000ffc00;
    sweep();
    lookups();
    i_resetn <= 1'h0;
    repeat (2) @(posedge i_core_clk);
    mreset();
    i_resetn <= 1'h1;
    sweep();
    wrap_up();
  end
endmodule
